// File: design/hub_cfg_pkg.sv
// Constants shared by the hub port configuration register bank.
// Assumes an 8-bit register port with byte addresses and three downstream ports.
package hub_cfg_pkg;
	localparam int NUM_PORTS = 3;
	localparam int LNUM_W = 2;

	localparam logic [7:0] OFS_CONFIG_BYTE_TWO = 8'h07;
	localparam logic [7:0] OFS_CONFIG_BYTE_THREE = 8'h08;
	localparam logic [7:0] OFS_FIXED_DEVICE_PORT_MASK = 8'h09;
	localparam logic [7:0] OFS_SELF_POWERED_PORT_OFF_MASK = 8'h0a;

	localparam logic [7:0] RST_CONFIG_BYTE_TWO = 8'h20;
	localparam logic [7:0] RST_CONFIG_BYTE_THREE = 8'h00;
	localparam logic [7:0] RST_FIXED_DEVICE_PORT_MASK = 8'h00;
	localparam logic [7:0] RST_SELF_POWERED_PORT_OFF_MASK = 8'h00;

	// Writable bits; all other bits are reserved
	localparam logic [7:0] WMASK_CONFIG_BYTE_TWO = 8'h08;
	localparam logic [7:0] WMASK_CONFIG_BYTE_THREE = 8'h09;
	localparam logic [7:0] WMASK_PORT_BITS = 8'h0e;

	localparam int BIT_COMPOUND = 3;
	localparam int BIT_REMAP_ENABLE = 3;
	localparam int BIT_STRING_ENABLE = 0;
	localparam int PORT_LSB = 1;

	localparam logic [7:0] RDATA_NONE = 8'h00;
	localparam logic [3:0] REMAP_MAX_LOGICAL = 4'h3;
endpackage : hub_cfg_pkg

// File: design/cfg_byte_reg.sv
// One 8-bit configuration byte with a fixed pattern in its reserved bits.
// Assumes the write strobe is a one-cycle pulse on clk.
`timescale 1ns/10ps
`default_nettype none
module cfg_byte_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hff
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic write,
	input wire logic [7:0] wdata,
	output logic [7:0] value
);
	typedef struct packed {
		logic [7:0] stored;
	} byte_state_t;

	byte_state_t s_q;
	byte_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (write) begin
			s_d.stored = wdata & WRITE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q.stored <= RESET_VAL & WRITE_MASK;
		end else begin
			s_q <= s_d;
		end
	end

	// Reserved bits never change, so writes to them cannot reach the hub
	assign value = s_q.stored | (RESET_VAL & ~WRITE_MASK);
endmodule : cfg_byte_reg
`default_nettype wire

// File: design/std_port_numbering.sv
// Standard port numbering: packs enabled physical ports into contiguous logical numbers.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
module std_port_numbering #(
	parameter int NPORTS = hub_cfg_pkg::NUM_PORTS,
	parameter int LW = hub_cfg_pkg::LNUM_W
) (
	input wire logic [NPORTS-1:0] off_bits,
	output logic [NPORTS*LW-1:0] logical_nums,
	output logic [LW-1:0] enabled_count
);
	always_comb begin
		logic [LW-1:0] run;
		run = '0;
		logical_nums = '0;
		for (int i = 0; i < NPORTS; i++) begin
			if (!off_bits[i]) begin
				run = run + LW'(1);
				logical_nums[i*LW +: LW] = run;
			end
		end
		enabled_count = run;
	end
endmodule : std_port_numbering
`default_nettype wire

// File: design/hub_port_config_regs.sv
// Port configuration register bank of a three-port hub: compound flag, numbering
// mode, string support, fixed-device and port-off masks, and the derived port view.
// Assumes a byte register port on clk; bus-powered mask, power select and remap
// tables come from neighbouring registers as plain inputs.
// Contract
// - Bit 3 of config_byte_two reports the hub as part of a compound device when set.
// - config_byte_two resets to 0x20, so the hub starts as not compound.
// - With remap_enable clear, standard numbering applies and the off masks decide enables.
// - In standard numbering, enabled ports above a disabled one shift down to stay contiguous.
// - With remap_enable set, numbering and disabling come from the remap tables instead.
// - Bit 0 of config_byte_three enables string descriptor support.
// - fixed_device_port_mask resets to zero and a set valid bit marks a port non-removable.
// - fixed_device_bits 1 to 3 belong to ports 1 to 3; other bits are reserved.
// - The hub reports which active ports hold a fixed device, which supplies its descriptors.
// - Self-powered with remap_enable clear, a port whose self_powered_off_bits bit is set is off.
// - Any mix of disabled ports is accepted and the enabled count is reported.
// - self_powered_off_bits 1 to 3 disable ports 1 to 3; other bits are reserved.
// - power_source_select high means self-powered and picks the self-powered mask.
// - Bus-powered operation uses bus_powered_off_bits in place of the self-powered mask.
`timescale 1ns/10ps
`default_nettype none
module hub_port_config_regs #(
	parameter int NPORTS = hub_cfg_pkg::NUM_PORTS,
	parameter int LW = hub_cfg_pkg::LNUM_W,
	parameter logic [7:0] CONFIG_BYTE_THREE_RESET = hub_cfg_pkg::RST_CONFIG_BYTE_THREE,
	parameter logic [7:0] SP_OFF_RESET = hub_cfg_pkg::RST_SELF_POWERED_PORT_OFF_MASK
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic power_source_select,
	input wire logic [7:0] bus_powered_off_bits,
	input wire logic [7:0] remap_table_fb,
	input wire logic [7:0] remap_table_fc,
	output logic compound_device,
	output logic string_enable,
	output logic remap_mode,
	output logic [NPORTS-1:0] port_enabled,
	output logic [NPORTS*LW-1:0] port_logical_nums,
	output logic [LW-1:0] enabled_port_count,
	output logic [NPORTS-1:0] fixed_device_logical
);
	typedef struct packed {
		logic [7:0] rdata;
		logic compound;
		logic string_en;
		logic remap;
		logic [NPORTS-1:0] port_en;
		logic [NPORTS*LW-1:0] logical;
		logic [LW-1:0] count;
		logic [NPORTS-1:0] fixed_log;
	} bank_state_t;

	bank_state_t s_q;
	bank_state_t s_d;

	logic [7:0] cfg_two;
	logic [7:0] cfg_three;
	logic [7:0] fixed_mask;
	logic [7:0] sp_off_mask;
	logic [NPORTS-1:0] off_sel;
	logic [NPORTS*LW-1:0] std_logical;
	logic [LW-1:0] std_count;
	logic [NPORTS*LW-1:0] map_logical;
	logic [LW-1:0] map_count;
	logic [15:0] remap_nibbles;

	// Reset values and reserved patterns live in the byte cells
	cfg_byte_reg #(
		.RESET_VAL(hub_cfg_pkg::RST_CONFIG_BYTE_TWO),
		.WRITE_MASK(hub_cfg_pkg::WMASK_CONFIG_BYTE_TWO)
	) u_cfg_two (
		.clk(clk),
		.sys_rst(sys_rst),
		.write(reg_write && reg_addr == hub_cfg_pkg::OFS_CONFIG_BYTE_TWO),
		.wdata(reg_wdata),
		.value(cfg_two)
	);

	cfg_byte_reg #(
		.RESET_VAL(CONFIG_BYTE_THREE_RESET),
		.WRITE_MASK(hub_cfg_pkg::WMASK_CONFIG_BYTE_THREE)
	) u_cfg_three (
		.clk(clk),
		.sys_rst(sys_rst),
		.write(reg_write && reg_addr == hub_cfg_pkg::OFS_CONFIG_BYTE_THREE),
		.wdata(reg_wdata),
		.value(cfg_three)
	);

	cfg_byte_reg #(
		.RESET_VAL(hub_cfg_pkg::RST_FIXED_DEVICE_PORT_MASK),
		.WRITE_MASK(hub_cfg_pkg::WMASK_PORT_BITS)
	) u_fixed_mask (
		.clk(clk),
		.sys_rst(sys_rst),
		.write(reg_write && reg_addr == hub_cfg_pkg::OFS_FIXED_DEVICE_PORT_MASK),
		.wdata(reg_wdata),
		.value(fixed_mask)
	);

	cfg_byte_reg #(
		.RESET_VAL(SP_OFF_RESET),
		.WRITE_MASK(hub_cfg_pkg::WMASK_PORT_BITS)
	) u_sp_off_mask (
		.clk(clk),
		.sys_rst(sys_rst),
		.write(reg_write && reg_addr == hub_cfg_pkg::OFS_SELF_POWERED_PORT_OFF_MASK),
		.wdata(reg_wdata),
		.value(sp_off_mask)
	);

	// Power source picks which off mask applies; reserved bits are never looked at
	assign off_sel = power_source_select ?
		sp_off_mask[hub_cfg_pkg::PORT_LSB +: NPORTS] :
		bus_powered_off_bits[hub_cfg_pkg::PORT_LSB +: NPORTS];

	std_port_numbering #(
		.NPORTS(NPORTS),
		.LW(LW)
	) u_std_numbering (
		.off_bits(off_sel),
		.logical_nums(std_logical),
		.enabled_count(std_count)
	);

	// Remap tables: one nibble per physical port, zero or out of range means off
	assign remap_nibbles = {remap_table_fc, remap_table_fb};

	always_comb begin
		logic [3:0] nib;
		nib = '0;
		map_logical = '0;
		map_count = '0;
		for (int i = 0; i < NPORTS; i++) begin
			nib = remap_nibbles[i*4 +: 4];
			if (nib != 4'h0 && nib <= hub_cfg_pkg::REMAP_MAX_LOGICAL) begin
				map_logical[i*LW +: LW] = nib[LW-1:0];
				map_count = map_count + LW'(1);
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.compound = cfg_two[hub_cfg_pkg::BIT_COMPOUND];
		s_d.string_en = cfg_three[hub_cfg_pkg::BIT_STRING_ENABLE];
		s_d.remap = cfg_three[hub_cfg_pkg::BIT_REMAP_ENABLE];
		s_d.logical = s_d.remap ? map_logical : std_logical;
		s_d.count = s_d.remap ? map_count : std_count;
		s_d.fixed_log = '0;
		for (int i = 0; i < NPORTS; i++) begin
			s_d.port_en[i] = s_d.logical[i*LW +: LW] != '0;
			// Fixed flag follows the port to its reported number; idle ports report none
			if (s_d.port_en[i] && fixed_mask[hub_cfg_pkg::PORT_LSB + i]) begin
				s_d.fixed_log[int'(s_d.logical[i*LW +: LW]) - 1] = 1'b1;
			end
		end
		if (reg_read) begin
			if (reg_addr == hub_cfg_pkg::OFS_CONFIG_BYTE_TWO) begin
				s_d.rdata = cfg_two;
			end else if (reg_addr == hub_cfg_pkg::OFS_CONFIG_BYTE_THREE) begin
				s_d.rdata = cfg_three;
			end else if (reg_addr == hub_cfg_pkg::OFS_FIXED_DEVICE_PORT_MASK) begin
				s_d.rdata = fixed_mask;
			end else if (reg_addr == hub_cfg_pkg::OFS_SELF_POWERED_PORT_OFF_MASK) begin
				s_d.rdata = sp_off_mask;
			end else begin
				s_d.rdata = hub_cfg_pkg::RDATA_NONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign compound_device = s_q.compound;
	assign string_enable = s_q.string_en;
	assign remap_mode = s_q.remap;
	assign port_enabled = s_q.port_en;
	assign port_logical_nums = s_q.logical;
	assign enabled_port_count = s_q.count;
	assign fixed_device_logical = s_q.fixed_log;

	// Checks: every derived output is one register stage behind the byte cells, so a
	// write sampled at edge N is visible at N+2 and a level input change one edge later.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence wr_to(logic [7:0] a);
		reg_write && reg_addr == a;
	endsequence

	sequence rd_of(logic [7:0] a);
		reg_read && reg_addr == a;
	endsequence

	// Register port: write effects, reset values and reserved bits
	a_compound_flag: assert property (
		wr_to(hub_cfg_pkg::OFS_CONFIG_BYTE_TWO) |-> ##2 compound_device == $past(reg_wdata[3], 2)
	) else $error("compound flag does not follow write");

	a_cfg_two_reset: assert property (
		$fell(sys_rst) |-> !compound_device ##0 (cfg_two == hub_cfg_pkg::RST_CONFIG_BYTE_TWO)
	) else $error("config byte two reset value wrong");

	a_string_flag: assert property (
		wr_to(hub_cfg_pkg::OFS_CONFIG_BYTE_THREE) |-> ##2 string_enable == $past(reg_wdata[0], 2)
	) else $error("string enable does not follow write");

	a_mode_follows: assert property (
		wr_to(hub_cfg_pkg::OFS_CONFIG_BYTE_THREE) |-> ##2 remap_mode == $past(reg_wdata[3], 2)
	) else $error("remap mode does not follow write");

	a_cfg_two_pattern: assert property (
		rd_of(hub_cfg_pkg::OFS_CONFIG_BYTE_TWO) |=> (reg_rdata & 8'hf7) == 8'h20
	) else $error("config byte two reserved bits read wrong");

	// Only the string and remap bits may ever read back as ones
	a_cfg_three_pattern: assert property (
		rd_of(hub_cfg_pkg::OFS_CONFIG_BYTE_THREE) |=> (reg_rdata & 8'hf6) == 8'h00
	) else $error("config byte three reserved bits not zero");

	a_fixed_reserved: assert property (
		(fixed_mask & 8'hf1) == 8'h00 && (sp_off_mask & 8'hf1) == 8'h00
	) else $error("reserved port bits changed");

	a_mask_read_reserved: assert property (
		reg_read && (reg_addr == hub_cfg_pkg::OFS_FIXED_DEVICE_PORT_MASK
		|| reg_addr == hub_cfg_pkg::OFS_SELF_POWERED_PORT_OFF_MASK)
		|=> (reg_rdata & 8'hf1) == 8'h00
	) else $error("port mask reserved bits read as ones");

	a_read_unmapped: assert property (
		reg_read && reg_addr > hub_cfg_pkg::OFS_SELF_POWERED_PORT_OFF_MASK |=> reg_rdata == 8'h00
	) else $error("unmapped read not zero");

	// A stray write above the map must leave every byte cell as it was
	a_unmapped_write: assert property (
		reg_write && reg_addr > hub_cfg_pkg::OFS_SELF_POWERED_PORT_OFF_MASK
		|=> $stable(cfg_two) && $stable(cfg_three) && $stable(fixed_mask) && $stable(sp_off_mask)
	) else $error("write to an unmapped address changed a register");

	a_fixed_reset: assert property (
		$fell(sys_rst) |-> fixed_mask == 8'h00 && fixed_device_logical == '0
	) else $error("fixed device mask not cleared by reset");

	// Standard numbering: ranks among enabled ports, counted without gaps
	a_std_first_port: assert property (
		!remap_mode && port_enabled[0] |-> port_logical_nums[LW-1:0] == LW'(1)
	) else $error("enabled first port not reported as port one");

	a_std_all_on: assert property (
		!remap_mode && port_enabled == '1 |-> port_logical_nums == 6'h39
	) else $error("standard numbering not one to one with all ports on");

	a_std_no_gaps: assert property (
		!remap_mode && !port_enabled[0] && port_enabled[1] |-> port_logical_nums[3:2] == 2'h1
	) else $error("port above a disabled one not shifted down");

	a_std_count: assert property (
		!remap_mode |-> enabled_port_count == 2'($countones(port_enabled))
	) else $error("enabled port count wrong");

	// Both halves are held a cycle so a mask or mode change in flight cannot trip it
	a_sp_port_off: assert property (
		power_source_select && $stable(power_source_select) && !cfg_three[3] && !$past(cfg_three[3])
		&& sp_off_mask[2] && $past(sp_off_mask[2]) |=> !port_enabled[1]
	) else $error("self-powered disabled port still enabled");

	a_bp_port_off: assert property (
		!power_source_select && bus_powered_off_bits[3] && !cfg_three[3] |=> !port_enabled[2]
		|| $changed(bus_powered_off_bits) || $changed(power_source_select) || $changed(cfg_three)
	) else $error("bus-powered disabled port still enabled");

	// Remap mode: the tables decide, whatever the port-off masks say
	a_remap_table: assert property (
		cfg_three[3] && remap_table_fb[3:0] == 4'h3 ##1 $stable(remap_table_fb) && $stable(cfg_three)
		|-> port_logical_nums[1:0] == 2'h3
	) else $error("remap table not applied");

	a_remap_over_mask: assert property (
		cfg_three[3] && power_source_select && sp_off_mask[1] && remap_table_fb[3:0] == 4'h3
		|=> port_enabled[0]
	) else $error("remap mode still applies the port-off mask");

	// Standard numbering: fixed devices are flagged on the number the host sees, never past the last port
	a_fixed_std_view: assert property (
		!remap_mode && port_enabled == '1
		|-> fixed_device_logical == $past(fixed_mask[hub_cfg_pkg::PORT_LSB +: NPORTS])
	) else $error("fixed device flags not reported on their ports");

	a_fixed_in_range: assert property (
		!remap_mode |-> (fixed_device_logical >> enabled_port_count) == '0
	) else $error("fixed device flagged beyond the reported ports");
endmodule : hub_port_config_regs
`default_nettype wire

// File: test/host_enum_model.sv
// Upstream host stand-in: latches what the hub reports at each edge.
// Assumes the hub's derived port view is registered on the same clk.
`timescale 1ns/10ps
`default_nettype none
module host_enum_model (
	input wire logic clk,
	input wire logic [1:0] port_count,
	input wire logic [2:0] fixed_logical,
	output logic [1:0] seen_count,
	output logic [2:0] seen_fixed
);
	// Fixed devices bring their own descriptors, so only the flag is kept
	always_ff @(posedge clk) begin
		seen_count <= port_count;
		seen_fixed <= fixed_logical;
	end
endmodule : host_enum_model
`default_nettype wire

// File: test/tb_hub_port_config_regs.sv
// Self-checking bench for the hub port configuration register bank.
// Assumes the byte register port contract: one-cycle strobes, data a cycle later.
`timescale 1ns/10ps
`default_nettype none
module tb_hub_port_config_regs;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic power_source_select = 1'b1;
	logic [7:0] bus_powered_off_bits = 8'h00;
	logic [7:0] remap_table_fb = 8'h00;
	logic [7:0] remap_table_fc = 8'h00;
	logic compound_device, string_enable, remap_mode;
	logic [2:0] port_enabled, fixed_device_logical, seen_fixed;
	logic [5:0] port_logical_nums;
	logic [1:0] enabled_port_count, seen_count;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;
	hub_port_config_regs uut (.clk(clk), .sys_rst(sys_rst), .reg_write(reg_write),
		.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .power_source_select(power_source_select),
		.bus_powered_off_bits(bus_powered_off_bits), .remap_table_fb(remap_table_fb),
		.remap_table_fc(remap_table_fc), .compound_device(compound_device),
		.string_enable(string_enable), .remap_mode(remap_mode), .port_enabled(port_enabled),
		.port_logical_nums(port_logical_nums), .enabled_port_count(enabled_port_count),
		.fixed_device_logical(fixed_device_logical));
	host_enum_model host (.clk(clk), .port_count(enabled_port_count),
		.fixed_logical(fixed_device_logical), .seen_count(seen_count), .seen_fixed(seen_fixed));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// Hang guard well above the roughly 80 cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt = error_cnt + 1;
			finish_test();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_write = 1'b0;
		// One idle edge keeps back-to-back calls from driving the strobe twice in a step
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		reg_read = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_read = 1'b0;
		@(posedge clk);
		#1 check(reg_rdata, exp);
	endtask : rd_check
	// Derived outputs lag a write by two edges; three leaves margin for input changes too
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic view_check(input logic [2:0] en, input logic [5:0] nums, input logic [1:0] cnt);
		check({5'h00, port_enabled}, {5'h00, en});
		check({2'h0, port_logical_nums}, {2'h0, nums});
		check({6'h00, enabled_port_count}, {6'h00, cnt});
		check({6'h00, seen_count}, {6'h00, cnt});
	endtask : view_check
	task automatic t_reset_values;
		rd_check(8'h07, 8'h20);
		rd_check(8'h08, 8'h00);
		rd_check(8'h09, 8'h00);
		rd_check(8'h0a, 8'h00);
		rd_check(8'h0b, 8'h00);
		check({7'h00, compound_device}, 8'h00);
		view_check(3'h7, 6'h39, 2'h3);
	endtask : t_reset_values
	task automatic t_compound_reserved;
		wr(8'h09, 8'hff);
		wr(8'h07, 8'hff);
		rd_check(8'h07, 8'h28);
		rd_check(8'h09, 8'h0e);
		settle();
		check({7'h00, compound_device}, 8'h01);
		check({5'h00, fixed_device_logical}, 8'h07);
		wr(8'h07, 8'h00);
		wr(8'h09, 8'h00);
		wr(8'h0b, 8'hff);
		settle();
		check({7'h00, compound_device}, 8'h00);
		rd_check(8'h0b, 8'h00);
	endtask : t_compound_reserved
	task automatic t_self_powered_off;
		// Port 2 off: port 3 moves down to number 2
		wr(8'h0a, 8'hf5);
		wr(8'h09, 8'h08);
		rd_check(8'h0a, 8'h04);
		settle();
		view_check(3'h5, 6'h21, 2'h2);
		check({5'h00, fixed_device_logical}, 8'h02);
		check({5'h00, seen_fixed}, 8'h02);
		wr(8'h0a, 8'h0e);
		settle();
		view_check(3'h0, 6'h00, 2'h0);
	endtask : t_self_powered_off
	task automatic t_bus_powered;
		// Self-powered mask still holds all ports off and must be ignored here
		power_source_select = 1'b0;
		bus_powered_off_bits = 8'h02;
		settle();
		view_check(3'h6, 6'h24, 2'h2);
		bus_powered_off_bits = 8'h08;
		settle();
		view_check(3'h3, 6'h09, 2'h2);
		power_source_select = 1'b1;
		settle();
		view_check(3'h0, 6'h00, 2'h0);
	endtask : t_bus_powered
	task automatic t_string_remap;
		remap_table_fb = 8'h13;
		remap_table_fc = 8'h02;
		wr(8'h08, 8'hff);
		rd_check(8'h08, 8'h09);
		settle();
		check({6'h00, remap_mode, string_enable}, 8'h03);
		view_check(3'h7, 6'h27, 2'h3);
		check({5'h00, fixed_device_logical}, 8'h02);
		wr(8'h08, 8'h01);
		settle();
		check({6'h00, remap_mode, string_enable}, 8'h01);
		view_check(3'h0, 6'h00, 2'h0);
	endtask : t_string_remap
	// Reset in mid-run must bring every byte back to its reset value
	task automatic t_mid_reset;
		wr(8'h07, 8'hff);
		wr(8'h09, 8'h0e);
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd_check(8'h07, 8'h20);
		rd_check(8'h09, 8'h00);
		check({6'h00, remap_mode, string_enable}, 8'h00);
		view_check(3'h7, 6'h39, 2'h3);
		check({5'h00, fixed_device_logical}, 8'h00);
	endtask : t_mid_reset
	initial begin
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_reset_values();
		t_compound_reserved();
		t_self_powered_off();
		t_bus_powered();
		t_string_remap();
		t_mid_reset();
		finish_test();
	end
endmodule : tb_hub_port_config_regs
`default_nettype wire
